// ---- hdl/opd_pkg.sv ----
// package: constants for the oscillator, prescaler and peripheral divider
package opd_pkg;

   // ==================================================================
   // timing
   localparam int CLK_PERIOD_NS = 50;         // 20 MHz oscillator model
   localparam int STAB_TIME_NS  = 100000;     // oscillator settling time
   localparam int STAB_CYCLES   =
      (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // rounded up
   localparam int STAB_W        = $clog2(STAB_CYCLES + 1);

   // ==================================================================
   // prescaler ratios
   localparam int PRE_RATIO_CERAMIC = 12;
   localparam int PRE_RATIO_CR      = 6;
   localparam int PRE_W             = 4;

   // ==================================================================
   // peripheral divider layout (bit k toggles at fdvin / 2^(k+1))
   localparam int DIV_W       = 14;
   localparam int TAP_NOISE   = 2;            // fdvin/8
   localparam int TAP_BZ_LOW  = 3;            // fdvin/16
   localparam int TAP_BZ_HIGH = 2;            // fdvin/8
   localparam int TAP_FREQ_OUT_SIGNAL_LO = 6;            // fdvin/128, slowest freq tap
   localparam int TAP_TIMER   = 6;            // fdvin/128
   localparam int TAP_SWATCH  = 6;            // fdvin/128
   localparam int TAP_FRAME   = 9;            // fdvin/1024
   localparam int TAP_TDATA   = 10;           // lowest timer data bit
   localparam int TICK_FAST   = 10;           // wrap span 1024
   localparam int TICK_MED    = 12;           // wrap span 4096
   localparam int TICK_SLOW   = 14;           // wrap span 16384

   // ==================================================================
   // one-third-duty frame: toggles every 384 divider inputs (/768)
   localparam int FR3_HALF = 384;
   localparam int FR3_W    = 9;

   // ==================================================================
   // reset values
   localparam logic [DIV_W-1:0] DIV_RST = 14'h0000;
   localparam logic [FR3_W-1:0] FR3_RST = 9'h000;
   localparam logic [PRE_W-1:0] PRE_RST = 4'h0;

   // oscillator state
   typedef enum logic [1:0] {
      OPD_RUN,
      OPD_SLEEP,
      OPD_START
   } opd_osc_e;

endpackage : opd_pkg

// ---- hdl/opd_pre_if.sv ----
// interface: link between the top and the prescaler
`timescale 1ns/100ps
interface opd_pre_if;
   logic ce;          // global clock enable
   logic run;         // oscillator running
   logic dvin_tick;   // one pulse per divider input period

   modport pre (input ce, input run, output dvin_tick);
   modport top (output ce, output run, input dvin_tick);
endinterface : opd_pre_if

// ---- hdl/opd_prescaler.sv ----
// prescaler: makes the divider input enable from the oscillator clock
`timescale 1ns/100ps
module opd_prescaler
   import opd_pkg::*;
#(
   parameter bit HIGH_SPEED = 1'b0,   // high-speed variant
   parameter bit OSC_ALT    = 1'b0    // 1: resistor-capacitor source
) (
   input wire logic clk,              // oscillator clock
   input wire logic rst,              // async reset, active high
   opd_pre_if.pre   p                 // enable in, tick out
);

   localparam logic [PRE_W-1:0] LAST =
      OSC_ALT ? PRE_W'(PRE_RATIO_CR - 1) : PRE_W'(PRE_RATIO_CERAMIC - 1);

   logic [PRE_W-1:0] cnt_r;

   // ==================================================================
   // modulo counter, cleared by reset so the phase is known
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= PRE_RST;
      end else if (p.ce && p.run && HIGH_SPEED) begin
         cnt_r <= (cnt_r == LAST) ? PRE_RST : cnt_r + 4'h1;
      end
   end

   // low-speed parts pass every oscillator cycle straight through
   assign p.dvin_tick = p.ce && p.run &&
                        (!HIGH_SPEED || cnt_r == LAST);

endmodule : opd_prescaler

// ---- hdl/opd_top.sv ----
// top: oscillator control, prescaler and peripheral divider taps
//
// Behaviour
// - oscillator source is a build-time parameter, never software set
// - high-speed part prescales by twelve (ceramic) or six (CR)
// - low-speed part feeds the oscillator straight into the divider
// - core runs on the undivided oscillator clock in every build
// - noise rejection sampling clock is divider input over eight
// - buzzer tones at input/16 and input/8; frequency taps /128 to /1
// - LCD frame is input/1024, or input/768 for one-third duty
// - clock timer counts on the input/128 tap
// - timer data bits 3..0 toggle at input/16384, 8192, 4096, 2048
// - fast, medium, slow ticks at input/1024, /4096, /16384
// - stopwatch is clocked from the input/128 tap
// - serial interface clock is the undivided oscillator clock
// - sleep exists only in CR low-speed or high-speed builds, by option
// - sleep instruction stops oscillator, core and all divider clocks
// - port interrupt ends sleep; software waits for oscillator settling
// - with sleep built in, oscillation detection is unavailable
`timescale 1ns/100ps
module opd_top
   import opd_pkg::*;
#(
   parameter bit HIGH_SPEED = 1'b0,  // 1: high-speed variant
   parameter bit OSC_ALT    = 1'b0,  // 0: crystal/ceramic, 1: CR
   parameter bit SLEEP_OPT  = 1'b0   // sleep function selected
) (
   input  wire logic       clk,               // oscillator clock
   input  wire logic       rst,               // initial reset
   input  wire logic       ce,                // clock enable
   input  wire logic       enter_sleep_op,    // sleep instruction pulse
   input  wire logic       port_wake,         // input port interrupt
   input  wire logic       duty_third,        // 1: one-third duty drive
   input  wire logic [2:0] freq_sel,          // 0:/128 .. 7:/1
   output logic            cpu_clk_en,        // core clock enable
   output logic            serial_clk_en,     // serial clock enable
   output logic            osc_running,       // oscillator on
   output logic            osc_stable,        // settling time elapsed
   output logic            osc_detect_avail,  // oscillation detect usable
   output logic            noise_clk,         // noise filter sampling
   output logic            buzzer_low_tone,   // low buzzer tone
   output logic            buzzer_high_tone,  // high buzzer tone
   output logic            freq_out_signal,   // selected frequency tap
   output logic            lcd_frame_signal,  // lcd frame square wave
   output logic            timer_clk,         // clock timer input
   output logic            stopwatch_clk,     // stopwatch input
   output logic [3:0]      timer_data,        // clock timer data bits
   output logic            fast_tick_flag,    // /1024 tick pulse
   output logic            medium_tick_flag,  // /4096 tick pulse
   output logic            slow_tick_flag     // /16384 tick pulse
);

   // sleep only in the CR low-speed part or the high-speed part
   localparam bit SLEEP_OK = SLEEP_OPT && (HIGH_SPEED || OSC_ALT);

   opd_osc_e           state_r;
   logic [STAB_W-1:0]  stab_r;
   logic [DIV_W-1:0]   div_r;
   logic [FR3_W-1:0]   fr3_cnt_r;
   logic               fr3_r;
   logic               run;
   logic               tick;
   logic [2:0]         wrap;
   logic [7:0]         freq_out_signal_taps;

   opd_pre_if pre_bus ();

   // ==================================================================
   // prescaler, source chosen at build time only
   assign pre_bus.ce  = ce;
   assign pre_bus.run = run;
   assign tick        = pre_bus.dvin_tick;

   opd_prescaler #(
      .HIGH_SPEED (HIGH_SPEED),
      .OSC_ALT    (OSC_ALT)
   ) u_pre (
      .clk (clk),
      .rst (rst),
      .p   (pre_bus)
   );

   // ==================================================================
   // oscillator state: running, stopped, restarting
   assign run = (state_r != OPD_SLEEP);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= OPD_RUN;
      end else if (ce) begin
         case (state_r)
            OPD_RUN: begin
               if (enter_sleep_op && SLEEP_OK) begin
                  state_r <= OPD_SLEEP;
               end
            end
            OPD_SLEEP: begin
               if (port_wake) begin
                  state_r <= OPD_START;
               end
            end
            OPD_START: begin
               if (stab_r == '0) begin
                  state_r <= OPD_RUN;
               end
            end
            default: begin
               state_r <= OPD_RUN;
            end
         endcase
      end
   end

   // settling countdown; divider runs meanwhile, software must wait
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stab_r <= '0;
      end else if (ce) begin
         if (state_r == OPD_SLEEP && port_wake) begin
            stab_r <= STAB_W'(STAB_CYCLES - 1);
         end else if (state_r == OPD_START && stab_r != '0) begin
            stab_r <= stab_r - 1'b1;
         end
      end
   end

   // ==================================================================
   // peripheral divider chain and one-third-duty frame counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_r <= DIV_RST;
      end else if (tick) begin
         div_r <= div_r + 14'h0001;
      end
   end

   // 768 is not a power of two, so it gets its own modulo-384 stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fr3_cnt_r <= FR3_RST;
         fr3_r     <= 1'b0;
      end else if (tick) begin
         if (fr3_cnt_r == FR3_W'(FR3_HALF - 1)) begin
            fr3_cnt_r <= FR3_RST;
            fr3_r     <= ~fr3_r;
         end else begin
            fr3_cnt_r <= fr3_cnt_r + 9'h001;
         end
      end
   end

   // ==================================================================
   // tick flags: a pulse when the low span of the divider wraps
   localparam int TICK_SPAN [3] = '{TICK_FAST, TICK_MED, TICK_SLOW};
   logic [2:0] tick_r;

   generate
      for (genvar g = 0; g < 3; g++) begin : g_tick
         assign wrap[g] = tick && (&div_r[TICK_SPAN[g]-1:0]);
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               tick_r[g] <= 1'b0;
            end else if (ce) begin
               tick_r[g] <= wrap[g];
            end
         end
      end
   endgenerate

   assign fast_tick_flag   = tick_r[0];
   assign medium_tick_flag = tick_r[1];
   assign slow_tick_flag   = tick_r[2];

   // ==================================================================
   // frequency taps: index 0 is /128, index 7 is the divider input
   // itself; in low-speed builds /1 therefore reads as a steady high
   assign freq_out_signal_taps = {tick, div_r[0], div_r[1], div_r[2],
                       div_r[3], div_r[4], div_r[5], div_r[TAP_FREQ_OUT_SIGNAL_LO]};

   // ==================================================================
   // registered tap outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         noise_clk        <= 1'b0;
         buzzer_low_tone  <= 1'b0;
         buzzer_high_tone <= 1'b0;
         freq_out_signal  <= 1'b0;
         lcd_frame_signal <= 1'b0;
         timer_clk        <= 1'b0;
         stopwatch_clk    <= 1'b0;
         timer_data       <= 4'h0;
      end else if (ce) begin
         noise_clk        <= div_r[TAP_NOISE];
         buzzer_low_tone  <= div_r[TAP_BZ_LOW];
         buzzer_high_tone <= div_r[TAP_BZ_HIGH];
         freq_out_signal  <= freq_out_signal_taps[freq_sel];
         lcd_frame_signal <= duty_third ? fr3_r
                                        : div_r[TAP_FRAME];
         timer_clk        <= div_r[TAP_TIMER];
         stopwatch_clk    <= div_r[TAP_SWATCH];
         timer_data       <= div_r[TAP_TDATA+3:TAP_TDATA];
      end
   end

   // ==================================================================
   // core and serial enables follow the oscillator, undivided
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cpu_clk_en       <= 1'b0;
         serial_clk_en    <= 1'b0;
         osc_running      <= 1'b0;
         osc_stable       <= 1'b0;
         osc_detect_avail <= 1'b0;
      end else if (ce) begin
         cpu_clk_en       <= run;
         serial_clk_en    <= run;
         osc_running      <= run;
         osc_stable       <= (state_r == OPD_RUN);
         osc_detect_avail <= !SLEEP_OK;
      end
   end

   // ==================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // cycles between divider input pulses, only counted while enabled
   logic [PRE_W-1:0] gap_r;
   logic             seen_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_r  <= PRE_RST;
         seen_r <= 1'b0;
      end else if (ce && run) begin
         gap_r  <= tick ? 4'h1 : gap_r + 4'h1;
         seen_r <= seen_r | tick;
      end
   end

   localparam logic [PRE_W-1:0] RATIO =
      OSC_ALT ? PRE_W'(PRE_RATIO_CR) : PRE_W'(PRE_RATIO_CERAMIC);

   sequence sleep_req_s;
      state_r == OPD_RUN && ce && enter_sleep_op && SLEEP_OK;
   endsequence
   sequence wake_req_s;
      state_r == OPD_SLEEP && ce && port_wake;
   endsequence

   prescale_gap_a: assert property (
      (HIGH_SPEED && tick && seen_r) |-> gap_r == RATIO)
      else $error("prescaler gap differs from ratio");
   direct_feed_a: assert property (
      (!HIGH_SPEED && ce && run) |-> tick)
      else $error("low-speed divider input missed a cycle");
   sleep_stop_a: assert property (
      sleep_req_s ##1 ce |=> !cpu_clk_en && !serial_clk_en)
      else $error("core clock kept running in sleep");
   sleep_freeze_a: assert property (
      state_r == OPD_SLEEP |=> $stable(div_r) && $stable(fr3_cnt_r))
      else $error("divider moved while oscillator stopped");
   sleep_only_a: assert property (
      SLEEP_OK || state_r != OPD_SLEEP)
      else $error("sleep entered in a build without it");
   wake_start_a: assert property (
      wake_req_s ##1 ce |=> osc_running && !osc_stable)
      else $error("wake did not restart oscillator");
   settle_count_a: assert property (
      (state_r == OPD_START && ce && stab_r != '0)
         |=> stab_r == $past(stab_r) - 1'b1)
      else $error("settling countdown stalled");
   fast_wrap_a: assert property (
      fast_tick_flag |-> div_r[TICK_FAST-1:0] == '0)
      else $error("fast tick off the /1024 boundary");
   slow_nest_a: assert property (
      slow_tick_flag |-> fast_tick_flag && medium_tick_flag)
      else $error("slow tick not aligned with faster ticks");
   frame_third_a: assert property (
      fr3_cnt_r < FR3_W'(FR3_HALF))
      else $error("one-third frame counter overran");
   timer_bits_a: assert property (
      ce |=> timer_data == $past(div_r[TAP_TDATA+3:TAP_TDATA]))
      else $error("timer data not from the divider");
   detect_off_a: assert property (
      (SLEEP_OK && $past(ce)) |-> !osc_detect_avail)
      else $error("oscillation detect offered with sleep");
   serial_core_a: assert property (
      serial_clk_en == cpu_clk_en)
      else $error("serial clock differs from core clock");
   medium_wrap_a: assert property (
      medium_tick_flag |-> fast_tick_flag && div_r[TICK_MED-1:0] == '0)
      else $error("medium tick off the /4096 boundary");
   frame_flip_a: assert property (
      (tick && fr3_cnt_r == FR3_W'(FR3_HALF - 1))
         |=> fr3_r != $past(fr3_r))
      else $error("one-third frame did not turn over");
   core_run_a: assert property (
      ce |=> cpu_clk_en == $past(run))
      else $error("core clock enable not the oscillator state");
   noise_tap_a: assert property (
      ce |=> noise_clk == $past(div_r[TAP_NOISE]))
      else $error("noise clock not from the /8 stage");

endmodule : opd_top

// ---- verification/tb_osc_prescaler_divider.sv ----
// testbench: self-checking bench for the oscillator prescaler and divider
`timescale 1ns/100ps
module tb_osc_prescaler_divider
   import opd_pkg::*;
   ;
   // ==================================================================
   // stimulus and observed signals
   localparam int DV = PRE_RATIO_CR;  // high-speed CR build, fdvin = clk/6
   logic       clk;
   logic       rst;
   logic       ce;
   logic       enter_sleep_op;
   logic       port_wake;
   logic       duty_third;
   logic [2:0] freq_sel;
   logic       cpu_clk_en;
   logic       serial_clk_en;
   logic       osc_running;
   logic       osc_stable;
   logic       osc_detect_avail;
   logic       noise_clk;
   logic       buzzer_low_tone;
   logic       buzzer_high_tone;
   logic       freq_out_signal;
   logic       lcd_frame_signal;
   logic       timer_clk;
   logic       stopwatch_clk;
   logic [3:0] timer_data;
   logic       fast_tick_flag;
   logic       medium_tick_flag;
   logic       slow_tick_flag;
   logic       ls_run;
   logic       ls_detect;
   logic       ls_freq_out_signal;
   logic       ls_fast;
   logic       ls_med;
   logic       ls_slow;
   logic [3:0] mon_sel;
   logic       mon;
   int         err_total;
   int         n_tests;

   // ==================================================================
   // device: high-speed CR build with sleep, so both the prescaler and sleep are built in
   opd_top #(.HIGH_SPEED(1'b1), .OSC_ALT(1'b1), .SLEEP_OPT(1'b1)) dut_u (
      .clk(clk), .rst(rst), .ce(ce), .enter_sleep_op(enter_sleep_op),
      .port_wake(port_wake), .duty_third(duty_third), .freq_sel(freq_sel),
      .cpu_clk_en(cpu_clk_en), .serial_clk_en(serial_clk_en),
      .osc_running(osc_running), .osc_stable(osc_stable),
      .osc_detect_avail(osc_detect_avail), .noise_clk(noise_clk),
      .buzzer_low_tone(buzzer_low_tone), .buzzer_high_tone(buzzer_high_tone),
      .freq_out_signal(freq_out_signal), .lcd_frame_signal(lcd_frame_signal),
      .timer_clk(timer_clk), .stopwatch_clk(stopwatch_clk),
      .timer_data(timer_data), .fast_tick_flag(fast_tick_flag),
      .medium_tick_flag(medium_tick_flag), .slow_tick_flag(slow_tick_flag));

   // low-speed crystal build: divider fed every clock, sleep not possible
   opd_top #(.HIGH_SPEED(1'b0), .OSC_ALT(1'b0), .SLEEP_OPT(1'b1)) dut_ls_u (
      .clk(clk), .rst(rst), .ce(ce), .enter_sleep_op(enter_sleep_op),
      .port_wake(port_wake), .duty_third(duty_third), .freq_sel(freq_sel),
      .cpu_clk_en(), .serial_clk_en(), .osc_running(ls_run),
      .osc_stable(), .osc_detect_avail(ls_detect), .noise_clk(),
      .buzzer_low_tone(), .buzzer_high_tone(), .freq_out_signal(ls_freq_out_signal),
      .lcd_frame_signal(), .timer_clk(), .stopwatch_clk(), .timer_data(),
      .fast_tick_flag(ls_fast), .medium_tick_flag(ls_med),
      .slow_tick_flag(ls_slow));

   // clock: inverted every half period
   always #(CLK_PERIOD_NS/2) clk = ~clk;

   // one measuring path shared by all nine measured taps keeps the measure task single
   always_comb begin
      case (mon_sel)
         4'h0:    mon = noise_clk;
         4'h1:    mon = buzzer_low_tone;
         4'h2:    mon = buzzer_high_tone;
         4'h3:    mon = freq_out_signal;
         4'h4:    mon = lcd_frame_signal;
         4'h5:    mon = timer_clk;
         4'h6:    mon = stopwatch_clk;
         4'h7:    mon = timer_data[0];
         default: mon = fast_tick_flag;
      endcase
   end

   // ==================================================================
   // shared helpers
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic tmo(input string nm);
      err_total++;
      $display("CHECK FAILED %s expected edge seen timeout", nm);
      finish_test();
   endtask : tmo

   // rise-to-rise period and high time in clk cycles; judge=0 only warms up
   task automatic meas(input logic [3:0] sel, input int per, input int hi,
                       input string nm, input bit judge);
      int   i;
      int   t;
      int   h;
      logic prv;
      i = 0;
      t = 0;
      h = 1;
      mon_sel = sel;
      @(negedge clk);
      while (mon !== 1'b0 && i < 2*per+20) begin
         @(negedge clk);
         i++;
      end
      while (mon !== 1'b1 && i < 2*per+20) begin
         @(negedge clk);
         i++;
      end
      if (i >= 2*per+20) tmo(nm);
      prv = 1'b1;
      while (t < 2*per+20) begin
         @(negedge clk);
         t++;
         if (mon === 1'b1 && prv === 1'b0) break;
         if (mon === 1'b1) h++;
         prv = mon;
      end
      if (t >= 2*per+20) tmo(nm);
      if (judge) begin
         chk({nm, " period"}, per, t);
         chk({nm, " high time"}, hi, h);
      end
   endtask : meas

   // ==================================================================
   // scenarios
   task automatic t_reset;
      int i;
      logic any;
      any = 1'b0;
      repeat (20) @(negedge clk);
      chk("outputs in reset", 0, {cpu_clk_en, osc_running, noise_clk,
          lcd_frame_signal, timer_data, fast_tick_flag});
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk("run flags", 4'hf, {cpu_clk_en, serial_clk_en, osc_running,
          osc_stable});
      chk("osc detect avail", 0, osc_detect_avail);
      // first noise edge needs four divider inputs, 24 clocks from reset
      for (i = 0; i < 17; i++) begin
         @(negedge clk);
         any = any | noise_clk;
      end
      chk("noise phase after reset", 0, any);
      $display("test reset done");
   endtask : t_reset

   task automatic t_taps;
      meas(4'h0, 8*DV, 4*DV, "noise_clk", 1'b1);
      meas(4'h1, 16*DV, 8*DV, "buzzer_low", 1'b1);
      meas(4'h2, 8*DV, 4*DV, "buzzer_high", 1'b1);
      meas(4'h5, 128*DV, 64*DV, "timer_clk", 1'b1);
      meas(4'h6, 128*DV, 64*DV, "stopwatch_clk", 1'b1);
      $display("test taps done");
   endtask : t_taps

   task automatic t_freq;
      int s;
      for (s = 0; s < 8; s++) begin
         freq_sel = s[2:0];
         meas(4'h3, (128*DV) >> s, 1, "freq warm", 1'b0);
         meas(4'h3, (128*DV) >> s, (s == 7) ? 1 : (64*DV) >> s,
              "freq_out", 1'b1);
      end
      $display("test freq done");
   endtask : t_freq

   task automatic t_lcd;
      duty_third = 1'b0;
      meas(4'h4, 1024*DV, 512*DV, "lcd quarter", 1'b1);
      duty_third = 1'b1;
      meas(4'h4, 768*DV, 384*DV, "lcd warm", 1'b0);
      meas(4'h4, 768*DV, 384*DV, "lcd third", 1'b1);
      $display("test lcd done");
   endtask : t_lcd

   task automatic t_timer;
      meas(4'h7, 2048*DV, 1024*DV, "timer_data0", 1'b1);
      meas(4'h8, 1024*DV, 1, "fast_tick", 1'b1);
      $display("test timer done");
   endtask : t_timer

   // ce low must freeze the divider input pulse and every tap
   task automatic t_freeze;
      logic [7:0] snap;
      int         n;
      n = 0;
      mon_sel = 4'h3;
      ce = 1'b0;
      @(negedge clk);
      snap = {noise_clk, buzzer_low_tone, freq_out_signal, lcd_frame_signal,
              timer_data};
      repeat (30) begin
         @(negedge clk);
         if (mon === 1'b1) n++;
      end
      chk("taps with ce low", snap, {noise_clk, buzzer_low_tone,
          freq_out_signal, lcd_frame_signal, timer_data});
      chk("input pulses with ce low", snap[5] ? 30 : 0, n);
      ce = 1'b1;
      $display("test freeze done");
   endtask : t_freeze

   task automatic t_sleep;
      int         i;
      logic [6:0] snap;
      port_wake = 1'b1;
      @(negedge clk) port_wake = 1'b0;
      repeat (3) @(negedge clk);
      chk("stable after stray wake", 1, osc_stable);
      enter_sleep_op = 1'b1;
      @(negedge clk) enter_sleep_op = 1'b0;
      repeat (3) @(negedge clk);
      chk("enables in sleep", 0, {cpu_clk_en, serial_clk_en, osc_running,
          osc_stable});
      chk("crystal low-speed build refuses sleep", 1, ls_run);
      snap = {noise_clk, buzzer_low_tone, lcd_frame_signal, timer_data};
      repeat (100) @(negedge clk);
      chk("taps in sleep", snap, {noise_clk, buzzer_low_tone,
          lcd_frame_signal, timer_data});
      port_wake = 1'b1;
      @(negedge clk) port_wake = 1'b0;
      i = 1;
      while (osc_running !== 1'b1 && i < 10) begin
         @(negedge clk);
         i++;
      end
      chk("wake latency short", 1, i <= 3);
      chk("unstable while settling", 0, osc_stable);
      // a sleep request while settling is refused
      enter_sleep_op = 1'b1;
      @(negedge clk) enter_sleep_op = 1'b0;
      i++;
      while (osc_stable !== 1'b1 && i < STAB_CYCLES+50) begin
         @(negedge clk);
         i++;
      end
      if (i >= STAB_CYCLES+50) tmo("osc_stable");
      chk("settling length", 1, i >= STAB_CYCLES && i <= STAB_CYCLES+6);
      chk("running after settling", 1, osc_running);
      $display("test sleep done");
   endtask : t_sleep

   // second reset mid-run; the low-speed divider then ticks from a known
   // phase, so the slow tick is seen without waiting a whole extra period
   task automatic t_lowspeed;
      int i;
      int f;
      int m;
      i = 0;
      f = 0;
      m = 0;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      chk("outputs in second reset", 0, {cpu_clk_en, osc_running,
          osc_stable, timer_data, ls_freq_out_signal});
      rst = 1'b0;
      while (ls_slow !== 1'b1 && i < 16384+20) begin
         @(negedge clk);
         i++;
         if (ls_fast === 1'b1 && f == 0) f = i;
         if (ls_med === 1'b1 && m == 0) m = i;
      end
      if (i >= 16384+20) tmo("ls slow_tick");
      chk("ls fast_tick first", 1024, f);
      chk("ls medium_tick first", 4096, m);
      chk("ls slow_tick first", 16384, i);
      chk("ls ticks nested", 3'h7, {ls_fast, ls_med, ls_slow});
      chk("ls freq_out_signal and detect", 2'h3, {ls_freq_out_signal, ls_detect});
      chk("timer data phase", 4'h2, timer_data);
      $display("test lowspeed done");
   endtask : t_lowspeed

   // ==================================================================
   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      enter_sleep_op = 1'b0;
      port_wake = 1'b0;
      duty_third = 1'b0;
      freq_sel = 3'h0;
      mon_sel = 4'h0;
      err_total = 0;
      n_tests = 0;
      t_reset();
      t_taps();
      t_freq();
      t_lcd();
      t_timer();
      t_freeze();
      t_sleep();
      t_lowspeed();
      finish_test();
   end
endmodule : tb_osc_prescaler_divider
